// >>> pkg/sidr_pkg.sv
// Constants for the sensor identification and device reset register bank
package sidr_pkg;
  // ==========================================================================
  // Register offsets (register index on the internal register port)
  localparam logic [5:0] OFS_BUS_ADDRESS   = 6'h00;
  localparam logic [5:0] OFS_VENDOR_CODE   = 6'h01;
  localparam logic [5:0] OFS_PART_REV      = 6'h02;
  localparam logic [5:0] OFS_FUNC_CAPS     = 6'h03;
  localparam logic [5:0] OFS_DEV_CONTROL   = 6'h05;
  localparam logic [5:0] OFS_TEMP_CAPS     = 6'h08;
  localparam logic [5:0] OFS_REMOTE_TEMP   = 6'h09;
  localparam logic [5:0] OFS_TEMP_CONTROL  = 6'h0a;
  localparam logic [5:0] OFS_CONV_RATE     = 6'h20;
  // ==========================================================================
  // Field positions
  localparam int        BUS_ADDR_W        = 3;
  localparam int        REV_LSB           = 11;
  localparam int        REV_W             = 5;
  localparam int        PART_W            = 11;
  localparam int        CTRL_RESET_BIT    = 0;
  localparam int        CTRL_SHUT_BIT     = 1;
  localparam int        CTRL_LOWPWR_BIT   = 2;
  localparam int        CTRL_BCAST_TOP    = 1;
  localparam int        TEMP_CTRL_W       = 4;
  localparam int        CONV_RATE_W       = 2;
  // ==========================================================================
  // Fixed and reset values
  localparam logic [2:0]  BUS_ADDR_STRAP_LO = 3'h1;
  localparam logic [2:0]  BUS_ADDR_STRAP_HI = 3'h7;
  localparam logic [15:0] FUNC_CAPS_VALUE   = 16'h0001;
  localparam logic [15:0] TEMP_CAPS_VALUE   = 16'h0549;
  localparam logic [15:0] DEV_CONTROL_RST   = 16'h0000;
  localparam logic [3:0]  TEMP_CONTROL_RST  = 4'h0;
  localparam logic [1:0]  CONV_RATE_RST     = 2'h2;
  // ==========================================================================
  // Timing: length of the internal device reset operation
  localparam int        CLK_PERIOD_NS     = 10;
  localparam int        DEV_RESET_NS      = 40;
  localparam int        DEV_RESET_CYCLES  = (DEV_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// >>> rtl/sidr_regs.sv
// Identification, capability and device reset register bank of the sensor
// ==========================================================================
// How it works
// - A full device reset runs when a one is written to the control reset bit outside a reset; power-up reset loads the defaults without asserting dev_reset_out.
// - A device reset abandons any operation in progress and normal operation restarts afterwards.
// - A device reset loads every register with its default value.
// - The reset bit clears by itself when the reset finishes, and no reset command is needed after power-up.
// - The three-bit bus address comes from the strap, low gives 001 and high gives 111.
// - The bus address follows the strap continuously and software writes cannot change it.
// - The bus address sits in the three low bits and the upper bits read as zero.
// - The part register shows a fixed revision in bits 15-11 and a fixed part code in bits 10-0.
// - The vendor code register returns a fixed 16-bit code.
// - The function capabilities register reads 1h, one temperature measurement function.
// - The temperature capabilities register reads 0549h.
`timescale 1ns/100ps
`default_nettype none

module sidr_regs #(
  parameter logic [15:0] VENDOR_CODE = 16'h5a5a,  // Arbitrary value
  parameter logic [4:0]  SILICON_REV = 5'h01,     // Arbitrary value
  parameter logic [10:0] PART_CODE   = 11'h155,   // Arbitrary value
  parameter int          RESET_CYCLES = sidr_pkg::DEV_RESET_CYCLES
) (
  input  wire logic        sys_clk_in,         // 100 MHz clock
  input  wire logic        srst_in,            // Power-up reset, sync, high
  input  wire logic        addr_strap_in,      // Address strap pin, async
  input  wire logic [5:0]  reg_addr_in,        // Register index
  input  wire logic        reg_wr_in,          // Write strobe, one cycle
  input  wire logic        reg_bcast_in,       // Write came by broadcast
  input  wire logic [15:0] reg_wdata_in,       // Write data
  input  wire logic        reg_rd_in,          // Read strobe, one cycle
  input  wire logic [15:0] remote_temp_in,     // Remote readout from measurement
  output logic      [15:0] reg_rdata_out,      // Read data, registered
  output logic             reg_rvalid_out,     // Read data valid, one cycle
  output logic             dev_reset_out,      // Device reset in progress
  output logic             shutdown_out,       // Shutdown mode
  output logic             low_power_out,      // Low-power mode
  output logic      [3:0]  temp_control_out,   // Temperature control bits
  output logic      [1:0]  conv_rate_out,      // Conversion rate select
  output logic      [2:0]  bus_address_out     // Strap-derived bus address
);

  // ==========================================================================
  // Elaboration checks; the reset counter is only three bits wide
  if (RESET_CYCLES < 1 || RESET_CYCLES > 7) begin : g_bad_reset_cycles
    $error("RESET_CYCLES must lie in 1..7");
  end

  localparam logic [2:0] RST_LAST = 3'(RESET_CYCLES - 1);

  // ==========================================================================
  // State
  typedef struct packed {
    logic        strap_meta;
    logic        strap_sync;
    logic        busy;
    logic [2:0]  rst_cnt;
    logic        shut;
    logic        lowpwr;
    logic [3:0]  temp_ctrl;
    logic [1:0]  conv_rate;
    logic [15:0] rdata;
    logic        rvalid;
  } sidr_state_t;

  sidr_state_t st;
  sidr_state_t next_st;
  logic [2:0]  bus_addr;
  logic [15:0] rd_mux;

  // Address follows the synchronised strap, never a register write
  assign bus_addr = st.strap_sync ? sidr_pkg::BUS_ADDR_STRAP_HI
                                  : sidr_pkg::BUS_ADDR_STRAP_LO;

  // Read multiplexer; unmapped and undefined offsets read zero
  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_addr_in)
      sidr_pkg::OFS_BUS_ADDRESS:  rd_mux = {13'h0000, bus_addr};
      sidr_pkg::OFS_VENDOR_CODE:  rd_mux = VENDOR_CODE;
      sidr_pkg::OFS_PART_REV:     rd_mux = {SILICON_REV, PART_CODE};
      sidr_pkg::OFS_FUNC_CAPS:    rd_mux = sidr_pkg::FUNC_CAPS_VALUE;
      sidr_pkg::OFS_DEV_CONTROL: begin
        rd_mux[sidr_pkg::CTRL_RESET_BIT]  = st.busy;
        rd_mux[sidr_pkg::CTRL_SHUT_BIT]   = st.shut;
        rd_mux[sidr_pkg::CTRL_LOWPWR_BIT] = st.lowpwr;
      end
      sidr_pkg::OFS_TEMP_CAPS:    rd_mux = sidr_pkg::TEMP_CAPS_VALUE;
      sidr_pkg::OFS_REMOTE_TEMP:  rd_mux = remote_temp_in;
      sidr_pkg::OFS_TEMP_CONTROL: rd_mux = {12'h000, st.temp_ctrl};
      sidr_pkg::OFS_CONV_RATE:    rd_mux = {14'h0000, st.conv_rate};
      default:                    rd_mux = 16'h0000;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_st            = st;
    next_st.strap_meta = addr_strap_in;
    next_st.strap_sync = st.strap_meta;
    next_st.rvalid     = reg_rd_in;
    if (reg_rd_in) begin
      next_st.rdata = rd_mux;
    end
    if (st.busy) begin
      // Hold every register at default; writes during reset are dropped
      next_st.shut      = 1'b0;
      next_st.lowpwr    = 1'b0;
      next_st.temp_ctrl = sidr_pkg::TEMP_CONTROL_RST;
      next_st.conv_rate = sidr_pkg::CONV_RATE_RST;
      if (st.rst_cnt == RST_LAST) begin
        next_st.busy    = 1'b0;
        next_st.rst_cnt = 3'h0;
      end else begin
        next_st.rst_cnt = st.rst_cnt + 3'h1;
      end
    end else if (reg_wr_in) begin
      // Read-only offsets fall through untouched
      unique case (reg_addr_in)
        sidr_pkg::OFS_DEV_CONTROL: begin
          next_st.shut = reg_wdata_in[sidr_pkg::CTRL_SHUT_BIT];
          if (!reg_bcast_in) begin
            // Broadcast may only touch the two low bits
            next_st.lowpwr = reg_wdata_in[sidr_pkg::CTRL_LOWPWR_BIT];
          end
          if (reg_wdata_in[sidr_pkg::CTRL_RESET_BIT]) begin
            // Reset wins over the rest of the word, so no mode leaks into the reset
            next_st.shut      = 1'b0;
            next_st.lowpwr    = 1'b0;
            next_st.temp_ctrl = sidr_pkg::TEMP_CONTROL_RST;
            next_st.conv_rate = sidr_pkg::CONV_RATE_RST;
            next_st.busy      = 1'b1;
            next_st.rst_cnt   = 3'h0;
          end
        end
        sidr_pkg::OFS_TEMP_CONTROL: begin
          if (!reg_bcast_in) begin
            next_st.temp_ctrl = reg_wdata_in[sidr_pkg::TEMP_CTRL_W-1:0];
          end
        end
        sidr_pkg::OFS_CONV_RATE: begin
          if (!reg_bcast_in) begin
            next_st.conv_rate = reg_wdata_in[sidr_pkg::CONV_RATE_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // State register; power-up reset gives defaults, no reset command needed
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      st.strap_meta <= 1'b0;
      st.strap_sync <= 1'b0;
      st.busy       <= 1'b0;
      st.rst_cnt    <= 3'h0;
      st.shut       <= 1'b0;
      st.lowpwr     <= 1'b0;
      st.temp_ctrl  <= sidr_pkg::TEMP_CONTROL_RST;
      st.conv_rate  <= sidr_pkg::CONV_RATE_RST;
      st.rdata      <= 16'h0000;
      st.rvalid     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs; the reset level tells the rest of the chip to abandon its work
  assign reg_rdata_out    = st.rdata;
  assign reg_rvalid_out   = st.rvalid;
  assign dev_reset_out    = st.busy;
  assign shutdown_out     = st.shut;
  assign low_power_out    = st.lowpwr;
  assign temp_control_out = st.temp_ctrl;
  assign conv_rate_out    = st.conv_rate;
  assign bus_address_out  = bus_addr;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  // Helper: an accepted write that sets the control reset bit
  logic ctrl_rst_wr;
  assign ctrl_rst_wr = reg_wr_in && !st.busy && reg_addr_in == sidr_pkg::OFS_DEV_CONTROL
                       && reg_wdata_in[0];

  // A reset write starts the reset with shutdown already cleared
  property p_reset_start;
    ctrl_rst_wr |=> dev_reset_out && shutdown_out == 1'b0;
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("reset not started");

  // The reset level stands for the default reset length, then drops
  property p_reset_length;
    $rose(dev_reset_out) |-> dev_reset_out [*4] ##1 !dev_reset_out;
  endproperty
  a_reset_length: assert property (p_reset_length) else $error("bad reset length");

  // Registers sit at their defaults while the reset runs
  property p_reset_defaults;
    dev_reset_out |=> conv_rate_out == 2'h2 && temp_control_out == 4'h0 && !low_power_out;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("default lost");

  // The reset bit reads back the reset level
  property p_reset_bit_reads;
    reg_rd_in && reg_addr_in == 6'h05 |=> reg_rvalid_out && reg_rdata_out[0] == $past(st.busy);
  endproperty
  a_reset_bit_reads: assert property (p_reset_bit_reads) else $error("reset bit");

  // Address register shows the strap address in its low bits only
  property p_addr_read;
    reg_rd_in && reg_addr_in == 6'h00 |=>
      reg_rdata_out == ($past(st.strap_sync) ? 16'h0007 : 16'h0001);
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("bus address");

  // Address follows the strap pin two cycles later, through the synchroniser
  property p_addr_follow;
    !$past(srst_in, 2) && !$past(srst_in) |->
      bus_address_out == ($past(addr_strap_in, 2) ? 3'h7 : 3'h1);
  endproperty
  a_addr_follow: assert property (p_addr_follow) else $error("address stale");

  // Part register carries revision above the part code
  property p_part_read;
    reg_rd_in && reg_addr_in == 6'h02 |=> reg_rdata_out[15:11] == SILICON_REV
                                          && reg_rdata_out[10:0] == PART_CODE;
  endproperty
  a_part_read: assert property (p_part_read) else $error("part register");

  // Vendor code reads back unchanged
  property p_vendor_read;
    reg_rd_in && reg_addr_in == 6'h01 |=> reg_rdata_out == VENDOR_CODE;
  endproperty
  a_vendor_read: assert property (p_vendor_read) else $error("vendor code");

  // Both capability words are fixed
  property p_caps_read;
    reg_rd_in && (reg_addr_in == 6'h03 || reg_addr_in == 6'h08) |=>
      reg_rdata_out == ($past(reg_addr_in) == 6'h03 ? 16'h0001 : 16'h0549);
  endproperty
  a_caps_read: assert property (p_caps_read) else $error("capabilities");

  // A write to a read-only offset moves no control output
  property p_ro_write;
    reg_wr_in && reg_addr_in inside {6'h00, 6'h01, 6'h02, 6'h03, 6'h08} |=>
      $stable(conv_rate_out) && $stable(temp_control_out) && $stable(shutdown_out)
      && $stable(low_power_out);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only written");

  // Writes that land during a device reset are dropped and defaults hold
  property p_write_in_reset;
    dev_reset_out && reg_wr_in |=> !shutdown_out && !low_power_out
      && temp_control_out == sidr_pkg::TEMP_CONTROL_RST
      && conv_rate_out == sidr_pkg::CONV_RATE_RST;
  endproperty
  a_write_in_reset: assert property (p_write_in_reset) else $error("write in reset");

  // Broadcast reaches only the shutdown and reset bits of the control word
  property p_bcast_limited;
    reg_wr_in && reg_bcast_in && !dev_reset_out && !reg_wdata_in[sidr_pkg::CTRL_RESET_BIT] |=>
      $stable(low_power_out) && $stable(temp_control_out) && $stable(conv_rate_out);
  endproperty
  a_bcast_limited: assert property (p_bcast_limited) else $error("broadcast leak");

  // Outside a device reset the reset bit reads back as zero
  property p_reset_bit_clear;
    reg_rd_in && reg_addr_in == 6'h05 && !dev_reset_out |=> reg_rdata_out[0] == 1'b0;
  endproperty
  a_reset_bit_clear: assert property (p_reset_bit_clear) else $error("reset bit stuck");

  // In normal operation the mode bits take the written value
  property p_ctrl_write;
    reg_wr_in && !reg_bcast_in && !dev_reset_out && reg_addr_in == 6'h05 && !reg_wdata_in[0] |=>
      shutdown_out == $past(reg_wdata_in[1]) && low_power_out == $past(reg_wdata_in[2]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  // Outside a reset the temperature control word is writable
  property p_temp_write;
    reg_wr_in && !reg_bcast_in && !dev_reset_out && reg_addr_in == 6'h0a |=>
      temp_control_out == $past(reg_wdata_in[3:0]);
  endproperty
  a_temp_write: assert property (p_temp_write) else $error("temp control lost");

  // Conversion rate select is writable in normal operation
  property p_rate_write;
    reg_wr_in && !reg_bcast_in && !dev_reset_out && reg_addr_in == 6'h20 |=>
      conv_rate_out == $past(reg_wdata_in[1:0]);
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate write lost");

  // Main scenarios: soft reset, strap high, broadcast, write in reset, read-only write
  c_soft_reset: cover property (ctrl_rst_wr ##1 dev_reset_out [*4] ##1 !dev_reset_out);
  c_strap_high: cover property (reg_rd_in && reg_addr_in == 6'h00 && st.strap_sync);
  c_bcast_ctrl: cover property (reg_wr_in && reg_bcast_in && reg_addr_in == 6'h05);
  c_wr_in_reset: cover property (dev_reset_out && reg_wr_in);
  c_ro_write: cover property (reg_wr_in && reg_addr_in == 6'h01);

endmodule // sidr_regs

`default_nettype wire

// >>> tb/sidr_master_model.sv
// Bus master model that issues register reads and writes to the bank
`timescale 1ns/100ps
`default_nettype none

module sidr_master_model (
  input  wire logic        sys_clk_in,     // Bench clock
  input  wire logic [15:0] reg_rdata_in,   // Read data from bank
  input  wire logic        reg_rvalid_in,  // Read data valid
  output logic      [5:0]  reg_addr_out,   // Register index
  output logic             reg_wr_out,     // Write strobe
  output logic             reg_bcast_out,  // Broadcast qualifier
  output logic      [15:0] reg_wdata_out,  // Write data
  output logic             reg_rd_out      // Read strobe
);
  // ==========================================================================
  // Idle bus at time zero
  initial begin
    reg_addr_out = 6'h3f;
    reg_wr_out = 1'b0;
    reg_bcast_out = 1'b0;
    reg_wdata_out = 16'h0000;
    reg_rd_out = 1'b0;
  end

  // One-cycle write; released address and data lines show inverted values, not the old ones
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic b);
    @(negedge sys_clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_bcast_out = b;
    reg_wr_out = 1'b1;
    @(negedge sys_clk_in);
    reg_wr_out = 1'b0;
    reg_bcast_out = 1'b0;
    reg_wdata_out = ~d;
    reg_addr_out = ~a;
  endtask

  // One-cycle read; valid stands only one cycle, so data is taken mid-cycle
  task automatic rd(input logic [5:0] a, output logic [15:0] q);
    @(negedge sys_clk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge sys_clk_in);
    q = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 16'hxxxx;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
  endtask
endmodule // sidr_master_model

`default_nettype wire

// >>> tb/sidr_regs_test.sv
// Self-checking bench for the identification and device reset registers
`timescale 1ns/100ps
`default_nettype none

module sidr_regs_test;
  logic        sys_clk_in;
  logic        srst_in;
  logic        addr_strap_in;
  logic [5:0]  addr;
  logic        wr;
  logic        bc;
  logic [15:0] wdata;
  logic        rd;
  logic [15:0] rdata;
  logic        rvalid;
  logic        dev_rst;
  logic        shut;
  logic        lowp;
  logic [3:0]  tctl;
  logic [1:0]  crate;
  logic [2:0]  baddr;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [15:0] q;
  localparam logic [15:0] VC = 16'h3c96;    // Arbitrary value
  localparam logic [4:0]  RV = 5'h03;       // Arbitrary value
  localparam logic [10:0] PC = 11'h2a7;     // Arbitrary value
  localparam logic [15:0] RT = 16'h1b40;    // Remote readout word

  sidr_regs #(.VENDOR_CODE(VC), .SILICON_REV(RV), .PART_CODE(PC), .RESET_CYCLES(4)) i_dut (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .addr_strap_in(addr_strap_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_bcast_in(bc), .reg_wdata_in(wdata),
    .reg_rd_in(rd), .remote_temp_in(RT), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .dev_reset_out(dev_rst), .shutdown_out(shut), .low_power_out(lowp),
    .temp_control_out(tctl), .conv_rate_out(crate), .bus_address_out(baddr));

  sidr_master_model i_mst (
    .sys_clk_in(sys_clk_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_addr_out(addr), .reg_wr_out(wr), .reg_bcast_out(bc),
    .reg_wdata_out(wdata), .reg_rd_out(rd));

  // ==========================================================================
  // Clock, and a cycle ceiling so a hung handshake cannot stall the run
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      final_report();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Every fixed register, re-read after a write of all ones
  task automatic t_fixed();
    logic [5:0]  ad [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h08, 6'h09, 6'h30, 6'h0b, 6'h04};
    logic [15:0] ex [9] = '{{13'h0, sidr_pkg::BUS_ADDR_STRAP_LO}, VC, {RV, PC},
                            16'h0001, 16'h0549, RT, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 9; i++) begin
      i_mst.rd(ad[i], q);
      check(q, ex[i]);
      i_mst.wr(ad[i], 16'hffff, 1'b0);
      i_mst.rd(ad[i], q);
      check(q, ex[i]);
    end
  endtask

  // Strap level selects the address and a write cannot override it
  task automatic t_strap();
    addr_strap_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    check({13'h0, baddr}, 16'h0007);
    i_mst.wr(6'h00, 16'h0000, 1'b0);
    i_mst.rd(6'h00, q);
    check(q, 16'h0007);
    addr_strap_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    check({13'h0, baddr}, 16'h0001);
  endtask

  // Soft reset returns written registers to defaults and self-clears
  task automatic t_soft_reset();
    i_mst.wr(6'h0a, 16'h000f, 1'b0);
    i_mst.wr(6'h20, 16'h0001, 1'b0);
    i_mst.wr(6'h05, 16'h0006, 1'b0);
    check({8'h0, shut, lowp, tctl, crate}, 16'h00fd);
    i_mst.wr(6'h05, 16'h0001, 1'b0);
    @(negedge sys_clk_in);
    check({15'h0, dev_rst}, 16'h0001);
    i_mst.wr(6'h0a, 16'h000f, 1'b0);
    for (int n = 0; n < 10 && dev_rst !== 1'b0; n++) @(negedge sys_clk_in);
    check({15'h0, dev_rst}, 16'h0000);
    check({8'h0, shut, lowp, tctl, crate}, 16'h0002);
    i_mst.rd(6'h05, q);
    check(q, 16'h0000);
    i_mst.rd(6'h20, q);
    check(q, 16'h0002);
  endtask

  // Broadcast reaches only the low control bits
  task automatic t_bcast();
    i_mst.wr(6'h05, 16'h0006, 1'b1);
    i_mst.wr(6'h0a, 16'h000f, 1'b1);
    check({8'h0, shut, lowp, tctl, crate}, 16'h0082);
    i_mst.wr(6'h05, 16'h0000, 1'b0);
  endtask

  // Main sequence
  initial begin
    srst_in = 1'b1;
    addr_strap_in = 1'b0;
    repeat (8) @(negedge sys_clk_in);
    srst_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    check({8'h0, shut, lowp, tctl, crate}, 16'h0002);
    t_fixed();
    t_strap();
    t_soft_reset();
    t_bcast();
    final_report();
  end
endmodule // sidr_regs_test

`default_nettype wire
